// *** gli_gpio_led.sv ***
// Purpose: Three general-purpose pins that may each show a status LED instead
// Assumes: Pin mode and data come from the control register space as plain inputs
// Notes: LED outputs are active low and open-drain
// How it works
// [R1] Each pin is input, push-pull output or open-drain output by its mode.
// [R2] A pin in LED mode only pulls low, otherwise releases.
// [R3] Speed LED low at 100, during negotiation or unplugged; high only at 10.
// [R4] Link/activity LED low while link valid and no blink running.
// [R5] Activity releases the link/activity LED for 80 ms.
// [R6] After a dark phase it stays low at least 80 ms before the next.
// [R7] Duplex LED low while the link is full duplex.
// [R8] Duplex LED dark in half duplex or no link; link LED dark without link.
`timescale 1ns/1ps
module gli_gpio_led
  import gli_pkg::*;
#(
  parameter int BLINK_CYCLES = BLINK_CYC
) (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire gli_mode_t pinMode [GLI_PINS],
  input wire logic [GLI_PINS-1:0] pinOutData,
  input wire gli_link_t linkState,
  input wire logic [GLI_PINS-1:0] pinIn,
  output logic [GLI_PINS-1:0] pinOut,
  output logic [GLI_PINS-1:0] pinOe,
  output logic [GLI_PINS-1:0] pinInData,
  output logic speed_led_n,
  output logic link_activity_led_n,
  output logic duplex_led_n
);

  typedef enum logic [1:0] {
    GLI_LIT,
    GLI_DARK,
    GLI_HOLD
  } gli_blink_t;

  gli_blink_t blink_q;
  logic [31:0] cnt_q;
  logic actSeen_q;
  logic [GLI_PINS-1:0] sync1_q, sync2_q, sync3_q;
  logic [GLI_PINS-1:0] ledN;

  //////////////////////////////////////////////////////////////////////////////
  // Input synchroniser, change accepted when stages two and three agree
  // Pads are asynchronous, so stage one may go metastable; only stage two reads it,
  // and a level must survive two stages before the pin's input data follows it
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      sync1_q <= '0;
      sync2_q <= '0;
      sync3_q <= '0;
      pinInData <= '0;
    end else begin
      sync1_q <= pinIn;
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
      for (int i = 0; i < GLI_PINS; i++) begin
        if (sync2_q[i] == sync3_q[i]) begin
          pinInData[i] <= sync3_q[i]; // [R1]
        end
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Activity blink sequencer: lit, dark 80 ms, lit at least 80 ms
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      blink_q <= GLI_LIT;
      cnt_q <= '0;
      actSeen_q <= 1'b0;
    end else begin
      case (blink_q)
        GLI_LIT: begin
          // Activity remembered in the dark and hold phases starts the next blink here,
          // so a burst that falls inside the minimum lit time is not lost
          actSeen_q <= 1'b0;
          if (linkState.linkUp && (linkState.activity || actSeen_q)) begin
            blink_q <= GLI_DARK; // [R5]
            cnt_q <= '0;
          end
        end
        GLI_DARK: begin
          actSeen_q <= actSeen_q | linkState.activity;
          if (cnt_q == 32'(BLINK_CYCLES - 1)) begin
            blink_q <= GLI_HOLD; // [R6]
            cnt_q <= '0;
          end else begin
            cnt_q <= cnt_q + 32'h1;
          end
        end
        GLI_HOLD: begin
          actSeen_q <= actSeen_q | linkState.activity;
          if (cnt_q == 32'(BLINK_CYCLES - 1)) begin
            blink_q <= GLI_LIT; // [R6]
            cnt_q <= '0;
          end else begin
            cnt_q <= cnt_q + 32'h1;
          end
        end
        default: begin
          blink_q <= GLI_LIT;
          cnt_q <= '0;
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // LED levels, registered
  // Registering keeps the open-drain enables glitch free while link state bits settle;
  // a link lost mid-blink still shows dark, and the sequencer runs on to its end
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      speed_led_n <= 1'b0;
      link_activity_led_n <= 1'b1;
      duplex_led_n <= 1'b1;
    end else begin
      speed_led_n <= linkState.linkUp && !linkState.autoNeg && !linkState.speed100; // [R3]
      link_activity_led_n <= !(linkState.linkUp && blink_q != GLI_DARK); // [R4] [R8]
      duplex_led_n <= !(linkState.linkUp && linkState.fullDuplex); // [R7] [R8]
    end
  end

  // LED level per pin position, so the pin map lives in one place
  always_comb begin
    ledN = '1;
    ledN[SPEED_PIN] = speed_led_n;
    ledN[LINK_PIN] = link_activity_led_n;
    ledN[DUPLEX_PIN] = duplex_led_n;
  end

  //////////////////////////////////////////////////////////////////////////////
  // Pad drivers per pin
  // Open-drain and LED pins only ever drive low; the board pull-up gives the high level
  always_comb begin
    for (int i = 0; i < GLI_PINS; i++) begin
      case (pinMode[i])
        GLI_MODE_PP: begin
          pinOut[i] = pinOutData[i]; // [R1]
          pinOe[i] = 1'b1;
        end
        GLI_MODE_OD: begin
          pinOut[i] = 1'b0; // [R1]
          pinOe[i] = !pinOutData[i];
        end
        GLI_MODE_LED: begin
          pinOut[i] = 1'b0; // [R2]
          pinOe[i] = !ledN[i];
        end
        default: begin
          pinOut[i] = 1'b0;
          pinOe[i] = 1'b0;
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Checks
  dark_len_a: assert property (@(posedge sys_clk) disable iff (!arst_n) // [R5]
    (blink_q == GLI_DARK) |-> (cnt_q < 32'(BLINK_CYCLES)))
    else $error("dark phase overran");
  hold_after_a: assert property (@(posedge sys_clk) disable iff (!arst_n) // [R6]
    (blink_q == GLI_DARK && $past(blink_q) != GLI_DARK) |-> ($past(blink_q) == GLI_LIT))
    else $error("dark phase without lit phase before");
  link_lit_a: assert property (@(posedge sys_clk) disable iff (!arst_n) // [R4]
    ($past(arst_n) && $past(linkState.linkUp) && $past(blink_q) != GLI_DARK) |-> !link_activity_led_n)
    else $error("link LED not lit");
  speed_a: assert property (@(posedge sys_clk) disable iff (!arst_n) // [R3]
    $past(linkState.speed100) |-> !speed_led_n)
    else $error("speed LED high at 100");
  duplex_a: assert property (@(posedge sys_clk) disable iff (!arst_n) // [R7]
    $past(arst_n && linkState.linkUp && linkState.fullDuplex) |-> !duplex_led_n)
    else $error("duplex LED not lit");
  nolink_dark_a: assert property (@(posedge sys_clk) disable iff (!arst_n) // [R8]
    !$past(linkState.linkUp) |-> (link_activity_led_n && duplex_led_n))
    else $error("LED lit without link");
  led_od_a: assert property (@(posedge sys_clk) disable iff (!arst_n) // [R2]
    (pinMode[0] == GLI_MODE_LED) |-> (pinOut[0] == 1'b0 && pinOe[0] == !speed_led_n))
    else $error("LED pin not open drain");
  pp_drive_a: assert property (@(posedge sys_clk) disable iff (!arst_n) // [R1]
    (pinMode[1] == GLI_MODE_PP) |-> (pinOe[1] && pinOut[1] == pinOutData[1]))
    else $error("push-pull pin not driven");
  // Blink sequencer seen at the LED output and at its phase ends
  dark_out_a: assert property (@(posedge sys_clk) disable iff (!arst_n) // [R5]
    (blink_q == GLI_DARK) |=> link_activity_led_n)
    else $error("link LED lit in dark phase");
  hold_lit_a: assert property (@(posedge sys_clk) disable iff (!arst_n) // [R6]
    (blink_q == GLI_HOLD && linkState.linkUp) |=> !link_activity_led_n)
    else $error("link LED dark in hold phase");
  act_start_a: assert property (@(posedge sys_clk) disable iff (!arst_n) // [R5]
    (blink_q == GLI_LIT && linkState.linkUp && linkState.activity) |=> (blink_q == GLI_DARK))
    else $error("activity did not start a blink");
  act_remember_a: assert property (@(posedge sys_clk) disable iff (!arst_n) // [R6]
    (blink_q == GLI_HOLD && linkState.activity) |=> actSeen_q)
    else $error("activity in hold phase lost");
  dark_exit_a: assert property (@(posedge sys_clk) disable iff (!arst_n) // [R5]
    ($past(blink_q) == GLI_DARK && blink_q != GLI_DARK) |-> (blink_q == GLI_HOLD && $past(cnt_q) == 32'(BLINK_CYCLES - 1)))
    else $error("dark phase ended early");
  hold_exit_a: assert property (@(posedge sys_clk) disable iff (!arst_n) // [R6]
    ($past(blink_q) == GLI_HOLD && blink_q != GLI_HOLD) |-> (blink_q == GLI_LIT && $past(cnt_q) == 32'(BLINK_CYCLES - 1)))
    else $error("hold phase ended early");
  in_sync_a: assert property (@(posedge sys_clk) disable iff (!arst_n) // [R1]
    (sync2_q == sync3_q) |=> (pinInData == $past(sync3_q)))
    else $error("agreed input level not taken");

  //////////////////////////////////////////////////////////////////////////////
  // Pad checks repeated on every pin, whatever its position
  for (genvar g = 0; g < GLI_PINS; g++) begin : g_pad_chk
    pad_pp_a: assert property (@(posedge sys_clk) disable iff (!arst_n) // [R1]
      (pinMode[g] == GLI_MODE_PP) |-> (pinOe[g] && pinOut[g] == pinOutData[g]))
      else $error("push-pull pad not driven");
    pad_od_a: assert property (@(posedge sys_clk) disable iff (!arst_n) // [R1]
      (pinMode[g] == GLI_MODE_OD) |-> (pinOut[g] == 1'b0 && pinOe[g] == !pinOutData[g]))
      else $error("open-drain pad misdriven");
    pad_in_a: assert property (@(posedge sys_clk) disable iff (!arst_n) // [R1]
      (pinMode[g] == GLI_MODE_IN) |-> !pinOe[g])
      else $error("input pad driven");
    pad_led_a: assert property (@(posedge sys_clk) disable iff (!arst_n) // [R2]
      (pinMode[g] == GLI_MODE_LED) |-> (pinOut[g] == 1'b0 && pinOe[g] == !ledN[g]))
      else $error("LED pad not open drain");
  end

endmodule : gli_gpio_led

// *** gli_pkg.sv ***
// Purpose: Shared constants and carrier types for the pin and status LED block
// Assumes: 200 MHz system clock
// Notes: Pin mode encoding is local to this block
package gli_pkg;

  localparam int GLI_PINS = 3;
  localparam int CLK_MHZ = 200;
  localparam int BLINK_MS = 80;
  localparam int BLINK_CYC = BLINK_MS * 1000 * CLK_MHZ;
  localparam int SPEED_PIN = 0;
  localparam int LINK_PIN = 1;
  localparam int DUPLEX_PIN = 2;

  // Per-pin configuration
  typedef enum logic [1:0] {
    GLI_MODE_IN,
    GLI_MODE_PP,
    GLI_MODE_OD,
    GLI_MODE_LED
  } gli_mode_t;

  // Link state from the physical layer
  typedef struct packed {
    logic linkUp;
    logic speed100;
    logic autoNeg;
    logic fullDuplex;
    logic activity;
  } gli_link_t;

endpackage : gli_pkg

// *** gli_board.sv ***
// Purpose: Board model of the three pads with their pull-ups
// Assumes: LED and board pull-ups hold released pads high
// Notes: A released pad reads high, never the last driven value
`timescale 1ns/1ps
module gli_board
  import gli_pkg::*;
(
  input wire logic [GLI_PINS-1:0] pinOut,
  input wire logic [GLI_PINS-1:0] pinOe,
  output logic [GLI_PINS-1:0] padLvl
);
  // Driven pads follow the driver, released pads float up
  assign padLvl = (pinOut & pinOe) | ~pinOe;
endmodule : gli_board

// *** tb_top.sv ***
// Purpose: Self-checking bench for the pin and status LED block
// Assumes: Short blink count so phases fit a brief run
// Notes: Pads resolve through the board model
`timescale 1ns/1ps
module tb_top;
  import gli_pkg::*;
  localparam int B = 16;
  logic sys_clk = 1'h0;
  logic arst_n = 1'h0;
  gli_mode_t md [GLI_PINS];
  logic [2:0] od = 3'h0;
  logic [2:0] pd, po, oe, id;
  gli_link_t ls = 5'h00;
  logic sl, al, dl;
  int miscompares = 0;
  int checks = 0;
  int cyc = 0;
  always #2.5 sys_clk = ~sys_clk;
  gli_gpio_led #(.BLINK_CYCLES(B)) gli_gpio_led_i (.sys_clk(sys_clk), .arst_n(arst_n), .pinMode(md),
    .pinOutData(od), .linkState(ls), .pinIn(pd), .pinOut(po), .pinOe(oe), .pinInData(id),
    .speed_led_n(sl), .link_activity_led_n(al), .duplex_led_n(dl));
  gli_board gli_board_i (.pinOut(po), .pinOe(oe), .padLvl(pd));
  ////////////////////////////////////////////////////////////
  task cy(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : cy
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      $display("BAD %s exp %h got %h", n, e, g);
      miscompares++;
    end
  endtask : chk
  task print_verdict;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : print_verdict
  ////////////////////////////////////////////////////////////
  // Push-pull, open-drain and input pad modes seen at the pads; push-pull and input levels also read back
  task t_pins;
    @(posedge sys_clk) begin
      md <= '{default:GLI_MODE_PP};
      od <= 3'h5;
    end
    cy(6);
    chk("ppOe", 3'h7, oe);
    chk("ppIn", 3'h5, id);
    chk("ppOut", 3'h5, po);
    @(posedge sys_clk) md <= '{default:GLI_MODE_OD};
    cy(1);
    chk("odOe", 3'h2, oe);
    chk("odOut", 3'h0, po);
    @(posedge sys_clk) md <= '{default:GLI_MODE_IN};
    cy(6);
    chk("inOe", 3'h0, oe);
    chk("inIn", 3'h7, id);
    // Each pin its own mode: pin 0 push-pull high, pin 1 open-drain low, pin 2 input
    @(posedge sys_clk) begin
      md <= '{GLI_MODE_PP, GLI_MODE_OD, GLI_MODE_IN};
      od <= 3'h1;
    end
    cy(6);
    chk("mixOe", 3'h3, oe);
    chk("mixOut", 3'h1, po);
    chk("mixIn", 3'h5, id);
    $display("pins done");
  endtask : t_pins
  // LED levels for each link condition
  task t_leds;
    gli_link_t v [5];
    logic [2:0] want [5];
    logic [2:0] e;
    // Link conditions and the LED levels {duplex, link, speed} that the rules give for them
    v = '{5'h00, 5'h10, 5'h1a, 5'h14, 5'h12};
    want = '{3'h6, 3'h5, 3'h0, 3'h4, 3'h1};
    @(posedge sys_clk) md <= '{default:GLI_MODE_LED};
    foreach (v[i]) begin
      @(posedge sys_clk) ls <= v[i];
      cy(2);
      e = want[i];
      chk("leds", e, {dl, al, sl});
      chk("ledOe", 3'(~e), oe);
      chk("ledOut", 3'h0, po);
    end
    $display("leds done");
  endtask : t_leds
  // Dark phase length, then activity held back by the hold phase
  task t_blink;
    int n;
    n = 0;
    @(posedge sys_clk) ls <= 5'h11;
    @(posedge sys_clk) ls <= 5'h10;
    cy(1);
    repeat (B + 4) begin
      n += (al === 1'h1);
      cy(1);
    end
    chk("dark", B, n);
    @(posedge sys_clk) ls <= 5'h11;
    @(posedge sys_clk) ls <= 5'h10;
    cy(1);
    n = 0;
    repeat (B - 7) begin
      n += (al !== 1'h0);
      cy(1);
    end
    chk("hold", 3'h0, n);
    cy(1);
    chk("again", 3'h1, {2'h0, al});
    $display("blink done");
  endtask : t_blink
  // Reset in mid blink clears the sequencer and the LEDs
  task t_reset;
    @(posedge sys_clk) arst_n <= 1'h0;
    cy(1);
    chk("rstMid", 3'h6, {dl, al, sl});
    @(posedge sys_clk) arst_n <= 1'h1;
    cy(2);
    chk("rstLit", 3'h5, {dl, al, sl});
    $display("reset done");
  endtask : t_reset
  ////////////////////////////////////////////////////////////
  // Cycle ceiling against a hang
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 3000) begin
      miscompares++;
      print_verdict;
    end
  end
  // Main sequence
  initial begin
    md = '{default:GLI_MODE_IN};
    cy(7);
    chk("rst", 3'h6, {dl, al, sl});
    @(posedge sys_clk) arst_n <= 1'h1;
    t_pins;
    t_leds;
    t_blink;
    t_reset;
    print_verdict;
  end
endmodule : tb_top
